// >>> conv_engine.sv
// Conversion timer, threshold fault counting and status flags
`timescale 1ns/1ps
`include "light_sensor_consts.svh"
module conv_engine
    import light_sensor_pkg::*;
#(
    parameter int CYCLES_PER_US = `CLK_MHZ
) (
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    conv_if.eng       cv
);
    localparam eng_regs_t ENG_RST = '{st: ENG_IDLE, default: '0};

    if (CYCLES_PER_US < 1 || CYCLES_PER_US > 2000) begin : g_chk
        $error("CYCLES_PER_US out of range");
    end

    eng_regs_t   q;
    eng_regs_t   d;
    logic [31:0] lim;
    logic [15:0] sel;
    logic [3:0]  need;
    logic [3:0]  hnext;
    logic [3:0]  lnext;

    function automatic logic [31:0] conv_cycles(input logic [3:0] code);
        int us;
        case (code)
            4'h0: us = `CONV_US_0;
            4'h1: us = `CONV_US_1;
            4'h2: us = `CONV_US_2;
            4'h3: us = `CONV_US_3;
            4'h4: us = `CONV_US_4;
            4'h5: us = `CONV_US_5;
            4'h6: us = `CONV_US_6;
            4'h7: us = `CONV_US_7;
            4'h8: us = `CONV_US_8;
            4'h9: us = `CONV_US_9;
            4'hA: us = `CONV_US_10;
            default: us = `CONV_US_11;
        endcase
        return 32'(us * CYCLES_PER_US);
    endfunction

    always_comb begin
        d = q;
        d.eoc = 1'b0;
        lim = conv_cycles(cv.ctime);
        sel = cv.ch_sel ? cv.ch1 : cv.ch0;
        need = 4'h1 << cv.fault;
        hnext = (sel > cv.hi) ? ((q.hcnt == 4'h8) ? 4'h8 : q.hcnt + 4'h1) : 4'h0;
        lnext = (sel < cv.lo) ? ((q.lcnt == 4'h8) ? 4'h8 : q.lcnt + 4'h1) : 4'h0;
        if (cv.clr) begin
            d.ready = 1'b0;
            if (cv.latch) begin
                d.fh = 1'b0;
                d.fl = 1'b0;
            end
        end
        case (q.st)
            ENG_IDLE: begin
                if (cv.start || cv.cont) begin
                    d.st = ENG_RUN;
                    d.cnt = 32'h0000_0000;
                end
            end
            ENG_RUN: begin
                if (q.cnt >= lim - 32'h1) begin
                    d.eoc = 1'b1;
                    d.ready = 1'b1;
                    d.hcnt = hnext;
                    d.lcnt = lnext;
                    if (cv.latch) begin
                        d.fh = d.fh || (hnext >= need);
                        d.fl = d.fl || (lnext >= need);
                    end else begin
                        d.fh = hnext >= need;
                        d.fl = lnext >= need;
                    end
                    d.cnt = 32'h0000_0000;
                    d.st = cv.cont ? ENG_RUN : ENG_IDLE;
                end else begin
                    d.cnt = q.cnt + 32'h1;
                end
            end
            default: d = ENG_RST;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= ENG_RST;
        end else begin
            q <= d;
        end
    end

    assign cv.eoc    = q.eoc;
    assign cv.busy   = q.st == ENG_RUN;
    assign cv.ready  = q.ready;
    assign cv.flag_h = q.fh;
    assign cv.flag_l = q.fl;

    ready_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (q.st == ENG_RUN && q.cnt >= lim - 32'h1) |=> cv.ready && cv.eoc)
        else $error("ready flag not set at end of conversion");
    conv_early_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (q.st == ENG_RUN && q.cnt < lim - 32'h1) |=> !cv.eoc)
        else $error("conversion ended before its time");
    fault_need_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        ($rose(q.fh) && $stable(cv.fault)) |-> q.hcnt >= need)
        else $error("high flag raised before fault count reached");
    flag_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (cv.latch && q.fh && !cv.clr && $stable(cv.latch)) |=> q.fh)
        else $error("latched high flag dropped without clear");
endmodule

// >>> conv_if.sv
// Link between the register side and the conversion engine
`timescale 1ns/1ps
interface conv_if;
    logic        start;
    logic        cont;
    logic        clr;
    logic        latch;
    logic        ch_sel;
    logic [3:0]  ctime;
    logic [1:0]  fault;
    logic [15:0] ch0;
    logic [15:0] ch1;
    logic [15:0] hi;
    logic [15:0] lo;
    logic        eoc;
    logic        busy;
    logic        ready;
    logic        flag_h;
    logic        flag_l;
    modport ctrl (output start, cont, clr, latch, ch_sel, ctime, fault, ch0, ch1, hi, lo,
                  input eoc, busy, ready, flag_h, flag_l);
    modport eng  (input start, cont, clr, latch, ch_sel, ctime, fault, ch0, ch1, hi, lo,
                  output eoc, busy, ready, flag_h, flag_l);
endinterface

// >>> i2c_host_model.sv
// I2C host model that reaches the sensor registers
`timescale 1ns/1ps
module i2c_host_model #(
    parameter logic [6:0] TGT_ADDR = 7'h44
) (
    input  wire logic i_ref_clk,
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda_rel
);
    logic nack_seen = 1'b0;
    initial begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Start or repeated start, SDA falls six clocks after SCL rises, SCL falls six clocks later
    task automatic start_c;
        o_sda_rel = 1'b1;
        tick(3);
        o_scl = 1'b1;
        tick(6);
        o_sda_rel = 1'b0;
        tick(6);
        o_scl = 1'b0;
        tick(3);
    endtask
    task automatic stop_c;
        o_sda_rel = 1'b0;
        tick(3);
        o_scl = 1'b1;
        tick(6);
        o_sda_rel = 1'b1;
        tick(6);
    endtask
    // Eight bits MSB first, then the acknowledge bit
    task automatic byte_io(input logic [7:0] d, input logic ao, output logic [7:0] q,
                           output logic ai);
        logic [8:0] s;
        logic [8:0] r;
        s = {d, ao};
        for (int i = 8; i >= 0; i--) begin
            o_sda_rel = s[i];
            tick(3);
            o_scl = 1'b1;
            tick(3);
            r[i] = i_sda_line;
            tick(3);
            o_scl = 1'b0;
            tick(3);
        end
        q = r[8:1];
        ai = r[0];
    endtask
    task automatic send(input logic [7:0] d);
        logic [7:0] q;
        logic       a;
        byte_io(d, 1'b1, q, a);
        if (a !== 1'b0) nack_seen = 1'b1;
    endtask
    // Pointer write then one word, high byte first
    task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] w);
        start_c();
        send({TGT_ADDR, 1'b0});
        send(ptr);
        send(w[15:8]);
        send(w[7:0]);
        stop_c();
    endtask
    // Two words read from the pointer, host NACK on the last byte
    task automatic rd_reg(input logic [7:0] ptr, output logic [15:0] a, output logic [15:0] b);
        logic x;
        start_c();
        send({TGT_ADDR, 1'b0});
        send(ptr);
        start_c();
        send({TGT_ADDR, 1'b1});
        byte_io(8'hFF, 1'b0, a[15:8], x);
        byte_io(8'hFF, 1'b0, a[7:0], x);
        byte_io(8'hFF, 1'b0, b[15:8], x);
        byte_io(8'hFF, 1'b1, b[7:0], x);
        stop_c();
    endtask
endmodule

// >>> light_sensor_config_int.sv
// I2C register target, control registers and interrupt pin of the light sensor
`timescale 1ns/1ps
`include "light_sensor_consts.svh"
module light_sensor_config_int
    import light_sensor_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR      = 7'h44,
    parameter int         CYCLES_PER_US = `CLK_MHZ
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output wire logic        o_sda_out,
    output wire logic        o_sda_oe_n,
    input  wire logic        i_irq_pin,
    output wire logic        o_irq_pin,
    output wire logic        o_irq_pin_oe_n,
    input  wire logic [15:0] i_ch0_level,
    input  wire logic [15:0] i_ch1_level,
    input  wire logic [15:0] i_thresh_high,
    input  wire logic [15:0] i_thresh_low,
    output wire logic [3:0]  o_range_code,
    output wire logic        o_auto_range,
    output wire logic        o_fast_standby_exit
);
    localparam logic [15:0] MEAS_RST = `MEAS_CFG_RESET;
    localparam logic [15:0] INT_RST  = `INT_CFG_RESET;
    localparam cfg_regs_t   CFG_RST  = '{
        st: I_IDLE, scl_q: 1'b1, sda_q: 1'b1, ptr_ph: 1'b1, hi_ph: 1'b1,
        sda_oe_n: 1'b1, meas: MEAS_RST, intc: INT_RST[5:0], trig_q: 1'b1,
        irq_out: 1'b1, auto_rng: 1'b1, rng: MEAS_RST[`RANGE_MSB:`RANGE_LSB],
        default: '0
    };

    cfg_regs_t   q;
    cfg_regs_t   d;
    conv_if      cv ();
    logic        scl_rise;
    logic        scl_fall;
    logic        st_cond;
    logic        sp_cond;
    logic [15:0] rd_val;
    logic [15:0] wdata;
    logic [1:0]  mode;
    logic [1:0]  icfg;
    logic        burst;
    logic        dir_out;
    logic        pol;
    logic        hit;
    logic        active;

    conv_engine #(
        .CYCLES_PER_US (CYCLES_PER_US)
    ) u_engine (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .cv        (cv.eng)
    );

    assign mode    = q.meas[`MODE_MSB:`MODE_LSB];
    assign icfg    = q.intc[`ICFG_MSB:`ICFG_LSB];
    assign burst   = q.intc[`BURST_BIT];
    assign dir_out = q.intc[`DIR_BIT];
    assign pol     = q.meas[`POL_BIT];

    assign cv.start  = q.start;
    assign cv.cont   = mode == MODE_CONT;
    assign cv.clr    = q.clr;
    assign cv.latch  = q.meas[`LATCH_BIT];
    assign cv.ch_sel = q.intc[`CHSEL_BIT];
    assign cv.ctime  = q.meas[`CTIME_MSB:`CTIME_LSB];
    assign cv.fault  = q.meas[`FAULT_MSB:`FAULT_LSB];
    assign cv.ch0    = i_ch0_level;
    assign cv.ch1    = i_ch1_level;
    assign cv.hi     = i_thresh_high;
    assign cv.lo     = i_thresh_low;

    always_comb begin
        case (q.ptr)
            `MEAS_CFG_ADDR: rd_val = q.meas;
            `INT_CFG_ADDR:  rd_val = {INT_RST[15:6], q.intc};
            `FLAG_ADDR:     rd_val = {12'h000, 1'b0, cv.ready, cv.flag_h, cv.flag_l};
            default:        rd_val = 16'h0000;
        endcase
    end

    always_comb begin
        d = q;
        d.scl_q = i_scl;
        d.sda_q = i_sda;
        d.trig_q = i_irq_pin;
        d.start = 1'b0;
        d.clr = 1'b0;
        scl_rise = !q.scl_q && i_scl;
        scl_fall = q.scl_q && !i_scl;
        st_cond = q.scl_q && i_scl && q.sda_q && !i_sda;
        sp_cond = q.scl_q && i_scl && !q.sda_q && i_sda;
        wdata = {q.wr_msb, q.sh};
        hit = 1'b0;
        case (q.st)
            I_IDLE: ;
            I_ADDR, I_WR: begin
                if (scl_rise) begin
                    d.sh = {q.sh[6:0], i_sda};
                    d.bitc = q.bitc + 4'h1;
                end else if (scl_fall && q.bitc == 4'h8) begin
                    d.st = I_ACK;
                    d.sda_oe_n = 1'b0;
                    if (q.st == I_ADDR) begin
                        d.rw = q.sh[0];
                        if (q.sh[7:1] != DEV_ADDR) begin
                            d.st = I_IDLE;
                            d.sda_oe_n = 1'b1;
                        end
                    end else if (q.ptr_ph) begin
                        d.ptr = q.sh;
                        d.ptr_ph = 1'b0;
                    end else if (q.hi_ph) begin
                        d.wr_msb = q.sh;
                        d.hi_ph = 1'b0;
                    end else begin
                        d.hi_ph = 1'b1;
                        case (q.ptr)
                            `MEAS_CFG_ADDR: begin
                                d.meas = wdata & `MEAS_CFG_WMASK;
                                // With the pin as input the conversion waits for its trigger
                                if (dir_out && (wdata[`MODE_MSB:`MODE_LSB] == MODE_FORCED ||
                                    wdata[`MODE_MSB:`MODE_LSB] == MODE_ONESHOT)) begin
                                    d.start = 1'b1;
                                end
                            end
                            `INT_CFG_ADDR: d.intc = wdata[5:0] & `INT_CFG_WMASK;
                            `FLAG_ADDR:    d.clr = wdata != 16'h0000;
                            default: ;
                        endcase
                    end
                end
            end
            I_ACK, I_RACK: begin
                if (scl_rise) begin
                    d.nack = i_sda;
                end else if (scl_fall) begin
                    d.bitc = 4'h0;
                    if (q.st == I_ACK && !q.rw) begin
                        d.sda_oe_n = 1'b1;
                        d.st = I_WR;
                    end else if (q.st == I_RACK && q.nack) begin
                        d.sda_oe_n = 1'b1;
                        d.st = I_IDLE;
                    end else begin
                        d.st = I_RD;
                        if (!q.rd_lo) begin
                            d.word = rd_val;
                            d.sh = rd_val[15:8];
                            d.clr = q.ptr == `FLAG_ADDR;
                        end else begin
                            d.sh = q.word[7:0];
                        end
                        d.sda_oe_n = d.sh[7];
                    end
                end
            end
            I_RD: begin
                if (scl_fall) begin
                    if (q.bitc == 4'h7) begin
                        d.st = I_RACK;
                        d.sda_oe_n = 1'b1;
                        d.rd_lo = !q.rd_lo;
                        if (q.rd_lo && burst) begin
                            d.ptr = q.ptr + 8'h01;
                        end
                    end else begin
                        d.bitc = q.bitc + 4'h1;
                        d.sh = {q.sh[6:0], 1'b0};
                        d.sda_oe_n = q.sh[6];
                    end
                end
            end
            default: d.st = I_IDLE;
        endcase
        if (st_cond) begin
            d.st = I_ADDR;
            d.bitc = 4'h0;
            d.sda_oe_n = 1'b1;
            d.ptr_ph = 1'b1;
            d.hi_ph = 1'b1;
            d.rd_lo = 1'b0;
        end else if (sp_cond) begin
            d.st = I_IDLE;
            d.sda_oe_n = 1'b1;
        end
        // External trigger when the pin is an input
        if (!dir_out && !q.trig_q && i_irq_pin && !cv.busy &&
            (mode == MODE_FORCED || mode == MODE_ONESHOT)) begin
            d.start = 1'b1;
        end
        if (cv.eoc) begin
            d.eoc_cnt = q.eoc_cnt + 2'h1;
            if (mode == MODE_FORCED || mode == MODE_ONESHOT) begin
                d.meas[`MODE_MSB:`MODE_LSB] = MODE_OFF;
            end
            case (icfg)
                2'h1:    hit = 1'b1;
                2'h2:    hit = q.eoc_cnt[0];
                2'h3:    hit = q.eoc_cnt == 2'h3;
                default: hit = 1'b0;
            endcase
        end
        if (d.clr) begin
            d.conv_irq = 1'b0;
        end
        if (hit) begin
            d.conv_irq = 1'b1;
        end
        active = (icfg == 2'h0) ? (cv.flag_h || cv.flag_l) : q.conv_irq;
        d.irq_out = active ? pol : !pol;
        d.irq_oe_n = !dir_out;
        d.rng = q.meas[`RANGE_MSB:`RANGE_LSB];
        d.auto_rng = q.meas[`RANGE_MSB:`RANGE_LSB] == `RANGE_AUTO || mode == MODE_FORCED;
        d.bias = q.meas[`FAST_STANDBY_EXIT_BIT] && !cv.busy &&
                 (mode == MODE_FORCED || mode == MODE_ONESHOT);
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= CFG_RST;
        end else begin
            q <= d;
        end
    end

    assign o_sda_out           = q.sda_out;
    assign o_sda_oe_n          = q.sda_oe_n;
    assign o_irq_pin           = q.irq_out;
    assign o_irq_pin_oe_n      = q.irq_oe_n;
    assign o_range_code        = q.rng;
    assign o_auto_range        = q.auto_rng;
    assign o_fast_standby_exit = q.bias;

    rsv_bits_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        q.meas[14] == 1'b0 && q.intc[1] == 1'b0)
        else $error("reserved control bit is set");
    pin_dir_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        $changed(dir_out) |=> o_irq_pin_oe_n == !$past(dir_out))
        else $error("interrupt pin direction not followed");
    pin_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (icfg != 2'h0 && q.conv_irq && $stable(pol)) |=> o_irq_pin == $past(pol))
        else $error("interrupt pin not at asserted level");
    burst_ptr_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (q.st == I_RD && scl_fall && q.bitc == 4'h7 && q.rd_lo && !st_cond && !sp_cond)
        |=> q.ptr == $past(q.ptr) + {7'h00, $past(burst)})
        else $error("read pointer step wrong after word read");
    oneshot_end_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (cv.eoc && mode == MODE_ONESHOT && !(q.st == I_WR && scl_fall))
        |=> mode == MODE_OFF)
        else $error("one-shot did not return to power-down");
    addr_ack_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (q.st == I_ADDR && scl_fall && q.bitc == 4'h8 && q.sh[7:1] == DEV_ADDR && !sp_cond)
        |=> q.st == I_ACK ##1 o_sda_oe_n == 1'b0)
        else $error("own address not acknowledged");
    trig_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (!dir_out && !q.trig_q && i_irq_pin && !cv.busy &&
         (mode == MODE_FORCED || mode == MODE_ONESHOT)) |=> ##1 cv.busy)
        else $error("pin trigger did not start a conversion");
    irq_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (icfg != 2'h0 && !q.conv_irq) |=> o_irq_pin == !$past(pol))
        else $error("interrupt pin not at idle level");
    every_conv_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (cv.eoc && icfg == 2'h1) |=> q.conv_irq)
        else $error("conversion interrupt missed");
    wake_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (mode == MODE_OFF || mode == MODE_CONT) |=> !o_fast_standby_exit)
        else $error("quick wake outside one-shot");
    auto_rng_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (q.meas[`RANGE_MSB:`RANGE_LSB] == `RANGE_AUTO) |=> o_auto_range)
        else $error("auto range not reported");
    range_copy_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        1'b1 |=> o_range_code == $past(q.meas[`RANGE_MSB:`RANGE_LSB]))
        else $error("range code not passed on");
    sda_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (q.st == I_IDLE) |-> o_sda_oe_n)
        else $error("data line driven while idle");
endmodule

// >>> light_sensor_consts.svh
// Offsets, field positions, reset values and timing figures of the light sensor control block
`ifndef LIGHT_SENSOR_CONSTS_SVH
`define LIGHT_SENSOR_CONSTS_SVH
`define MEAS_CFG_ADDR   8'h0A
`define INT_CFG_ADDR    8'h0B
`define FLAG_ADDR       8'h0C
`define MEAS_CFG_RESET  16'h3208
`define INT_CFG_RESET   16'h8011
`define MEAS_CFG_WMASK  16'hBFFF
`define INT_CFG_WMASK   6'h3D
`define FAST_STANDBY_EXIT_BIT       15
`define RANGE_MSB       13
`define RANGE_LSB       10
`define CTIME_MSB       9
`define CTIME_LSB       6
`define MODE_MSB        5
`define MODE_LSB        4
`define LATCH_BIT       3
`define POL_BIT         2
`define FAULT_MSB       1
`define FAULT_LSB       0
`define CHSEL_BIT       5
`define DIR_BIT         4
`define ICFG_MSB        3
`define ICFG_LSB        2
`define BURST_BIT       0
`define RANGE_AUTO      4'hC
`define CLK_MHZ         125
`define CONV_US_0       600
`define CONV_US_1       1000
`define CONV_US_2       1800
`define CONV_US_3       3400
`define CONV_US_4       6500
`define CONV_US_5       12700
`define CONV_US_6       25000
`define CONV_US_7       50000
`define CONV_US_8       100000
`define CONV_US_9       200000
`define CONV_US_10      400000
`define CONV_US_11      800000
`endif

// >>> light_sensor_pkg.sv
// Types shared by the light sensor control block
package light_sensor_pkg;
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0, MODE_FORCED = 2'h1, MODE_ONESHOT = 2'h2, MODE_CONT = 2'h3
    } op_mode_t;
    typedef enum logic [5:0] {
        I_IDLE = 6'h01, I_ADDR = 6'h02, I_ACK = 6'h04,
        I_WR = 6'h08, I_RD = 6'h10, I_RACK = 6'h20
    } i2c_state_t;
    typedef enum logic [1:0] {ENG_IDLE = 2'h1, ENG_RUN = 2'h2} eng_state_t;
    typedef struct packed {
        eng_state_t  st;
        logic [31:0] cnt;
        logic [3:0]  hcnt;
        logic [3:0]  lcnt;
        logic        eoc;
        logic        ready;
        logic        fh;
        logic        fl;
    } eng_regs_t;
    typedef struct packed {
        logic        scl_q;
        logic        sda_q;
        i2c_state_t  st;
        logic [3:0]  bitc;
        logic [7:0]  sh;
        logic [7:0]  ptr;
        logic [7:0]  wr_msb;
        logic [15:0] word;
        logic        ptr_ph;
        logic        hi_ph;
        logic        rd_lo;
        logic        rw;
        logic        nack;
        logic        sda_oe_n;
        logic        sda_out;
        logic [15:0] meas;
        logic [5:0]  intc;
        logic        start;
        logic        clr;
        logic [1:0]  eoc_cnt;
        logic        conv_irq;
        logic        trig_q;
        logic        irq_out;
        logic        irq_oe_n;
        logic        bias;
        logic        auto_rng;
        logic [3:0]  rng;
    } cfg_regs_t;
endpackage

// >>> tb_top.sv
// Self-checking bench for the light sensor control block
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk;
    logic        resetn;
    logic        ext_trig;
    logic [15:0] ch0, ch1, hi, lo, a, b;
    wire         scl, sda_rel, sda_out, sda_oe_n, irq_out, irq_oe_n, auto_rng, fse;
    wire  [3:0]  rng;
    wire         sda_line = sda_rel & sda_oe_n;
    wire         irq_line = irq_oe_n ? ext_trig : irq_out;
    int          fail_count = 0;
    int          n_checks = 0;
    localparam logic [15:0] T0B [3] = '{16'h8015, 16'h8015, 16'h8031};
    localparam logic [15:0] T0A [3] = '{16'h3029, 16'h3029, 16'h3028};
    localparam logic [15:0] TFL [3] = '{16'h0004, 16'h0006, 16'h0005};
    light_sensor_config_int #(.DEV_ADDR(7'h44), .CYCLES_PER_US(1)) i_light_sensor_config_int (
        .i_ref_clk(ref_clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda_line),
        .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_irq_pin(irq_line),
        .o_irq_pin(irq_out), .o_irq_pin_oe_n(irq_oe_n), .i_ch0_level(ch0),
        .i_ch1_level(ch1), .i_thresh_high(hi), .i_thresh_low(lo), .o_range_code(rng),
        .o_auto_range(auto_rng), .o_fast_standby_exit(fse));
    i2c_host_model #(.TGT_ADDR(7'h44)) i_i2c_host_model (
        .i_ref_clk(ref_clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_rel(sda_rel));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        resetn = 1'b0;
        ch0 = 16'h0200;
        ch1 = 16'h0000;
        hi = 16'h0100;
        lo = 16'h0010;
        ext_trig = 1'b1;
        i_i2c_host_model.tick(2);
        resetn = 1'b1;
        i_i2c_host_model.tick(2);
        chk("range port", 16'hC, 16'(rng));
        chk("irq oe", 16'h0, 16'(irq_oe_n));
        chk("sda drive", 16'h0, 16'(sda_out));
        i_i2c_host_model.rd_reg(8'h0A, a, b);
        chk("meas reset", 16'h3208, a);
        chk("int reset", 16'h8011, b);
        i_i2c_host_model.wr_reg(8'h0A, 16'h888F);
        chk("range code", 16'h2, 16'(rng));
        chk("auto range", 16'h0, 16'(auto_rng));
        chk("quick wake", 16'h0, 16'(fse));
        chk("idle pin hi pol", 16'h0, 16'(irq_line));
        i_i2c_host_model.wr_reg(8'h0B, 16'h8001);
        chk("pin input", 16'h1, 16'(irq_oe_n));
        i_i2c_host_model.rd_reg(8'h0A, a, b);
        chk("meas rsvd", 16'h888F, a);
        chk("burst next", 16'h8001, b);
        i_i2c_host_model.wr_reg(8'h0B, 16'h8000);
        i_i2c_host_model.rd_reg(8'h0B, a, b);
        chk("no burst 1", 16'h8000, a);
        chk("no burst 2", 16'h8000, b);
        i_i2c_host_model.rd_reg(8'h20, a, b);
        chk("unmapped", 16'h0000, a | b);
        for (int k = 0; k < 3; k++) begin
            i_i2c_host_model.wr_reg(8'h0B, T0B[k]);
            i_i2c_host_model.wr_reg(8'h0A, T0A[k]);
            i_i2c_host_model.tick(700);
            chk("pin active", 16'h0, 16'(irq_line));
            i_i2c_host_model.rd_reg(8'h0C, a, b);
            chk("flags", TFL[k], a);
            chk("pin cleared", 16'h1, 16'(irq_line));
        end
        i_i2c_host_model.rd_reg(8'h0A, a, b);
        chk("mode done", 16'h3008, a);
        i_i2c_host_model.wr_reg(8'h0B, 16'h8001);
        i_i2c_host_model.wr_reg(8'h0A, 16'h8818);
        chk("auto forced", 16'h1, 16'(auto_rng));
        chk("wake armed", 16'h1, 16'(fse));
        ext_trig = 1'b0;
        i_i2c_host_model.tick(2);
        ext_trig = 1'b1;
        i_i2c_host_model.tick(4);
        chk("wake busy", 16'h0, 16'(fse));
        i_i2c_host_model.tick(700);
        chk("auto done", 16'h0, 16'(auto_rng));
        i_i2c_host_model.rd_reg(8'h0C, a, b);
        chk("trig flags", 16'h0006, a);
        ch0 = 16'hFFFF;
        ch1 = 16'h0005;
        hi = 16'h0400;
        lo = 16'h0008;
        i_i2c_host_model.wr_reg(8'h0B, 16'h8039);
        i_i2c_host_model.wr_reg(8'h0A, 16'h3038);
        i_i2c_host_model.tick(900);
        chk("one of two", 16'h1, 16'(irq_line));
        i_i2c_host_model.tick(300);
        chk("two of two", 16'h0, 16'(irq_line));
        i_i2c_host_model.wr_reg(8'h0A, 16'h3008);
        i_i2c_host_model.rd_reg(8'h0C, a, b);
        chk("ch1 flags", 16'h0005, a);
        chk("pin released", 16'h1, 16'(irq_line));
        chk("acks", 16'h0, 16'(i_i2c_host_model.nack_seen));
        tally_and_finish();
    end
endmodule
